/* design/ucr_channel.sv */
`timescale 1ns/10ps
// Functional notes
// RULE1: loopback is active exactly while modem control bit 4 is one.
// RULE2: in loopback transmit shift output feeds receive shift input.
// RULE3: in loopback serial output, rts and dtr pins are held inactive.
// RULE4: in loopback the cts, dsr, cd and ri pins are ignored.
// RULE5: all other uart functions continue normally during loopback.
// RULE6: automatic rts/cts flow control is dropped during loopback.
// RULE7: outside party keeps the receive pin high during loopback.
// RULE8: each channel owns a register set, picked by its own select.
// RULE9: divisor access off: address 0 reads receive, writes transmit holding.
// RULE10: divisor access on, not 0xbf: addresses 0, 1 reach divisor bytes.
// RULE11: fractional divisor at 2 needs divisor access, not 0xbf, enhanced.
// RULE12: divisor zero: addresses 0 and 1 read revision and identity codes.
// RULE13: divisor access off: address 1 is interrupt enable.
// RULE14: not 0xbf: address 2 reads interrupt status with fifo flags.
// RULE15: write at address 2 loads fifo control fields.
// RULE16: address 3 always reaches line control.
// RULE17: 4..7 are modem control, line status, modem status, scratch.
// RULE18: line control 0xbf: 2 is enhanced function, 4..7 flow characters.
// RULE19: extended fields are active only with enhanced bit 4 set.
// RULE20: extended fields ignore writes and read zero while disabled; here a write while disabled clears them to zero.
module ucr_channel
    import ucr_pkg::*;
#(
    parameter logic [7:0] REV_CODE = REV_CODE_DEF, // arbitrary value
    parameter logic [7:0] ID_CODE = ID_CODE_DEF    // arbitrary value
) (
    input wire logic clk_sys,                   // system clock
    input wire logic reset_n,                   // async reset, active low
    input wire logic chan_select_n,             // this channel's select, low
    input wire logic [ucr_pkg::AW-1:0] addr,    // register address
    input wire logic wr_n,                      // write strobe, low
    input wire logic rd_n,                      // read strobe, low
    input wire logic [ucr_pkg::DW-1:0] wdata,   // write data
    output logic [ucr_pkg::DW-1:0] rdata,       // read data, registered
    output logic rdata_oe,                      // data bus drive enable
    input wire logic [ucr_pkg::DW-1:0] rx_holding, // receive holding byte
    output logic rx_holding_pop,                // receive holding read pulse
    output logic [ucr_pkg::DW-1:0] tx_holding,  // transmit holding byte
    output logic tx_holding_push,               // transmit holding load pulse
    input wire logic [5:0] int_source,          // interrupt source code
    input wire logic int_source_rd_ack,         // unused-safe: kept low
    output logic isr_read,                      // interrupt status read pulse
    input wire logic [ucr_pkg::DW-1:0] line_status_in, // line status byte
    output logic line_status_read,              // line status read pulse
    input wire logic [3:0] modem_delta,         // delta cts,dsr,ri,cd
    output logic modem_status_read,             // modem status read pulse
    output logic fifo_rx_reset,                 // receive fifo reset pulse
    output logic fifo_tx_reset,                 // transmit fifo reset pulse
    output logic [ucr_pkg::DW-1:0] fifo_ctl,    // fifo control value
    output logic [ucr_pkg::DW-1:0] int_enable,  // interrupt enable value
    output logic [ucr_pkg::DW-1:0] line_ctl,    // line control value
    output logic [15:0] baud_divisor,           // integer divisor
    output logic [ucr_pkg::DW-1:0] frac_divisor, // fractional divisor
    output logic [ucr_pkg::DW-1:0] enh_func,    // enhanced function value
    output logic [31:0] flow_chars,             // xon1,xon2,xoff1,xoff2
    output logic auto_flow_allow,               // auto rts/cts permitted
    output logic loopback,                      // loopback active
    input wire logic tsr_out,                   // transmit shift output
    output logic rsr_in,                        // receive shift input
    input wire logic rx_pin,                    // serial receive pin
    output logic tx_pin,                        // serial transmit pin
    output logic rts_n_pin,                     // rts pin, low active
    output logic dtr_n_pin,                     // dtr pin, low active
    input wire logic cts_n_pin,                 // cts pin, low active
    input wire logic dsr_n_pin,                 // dsr pin, low active
    input wire logic cd_n_pin,                  // cd pin, low active
    input wire logic ri_n_pin                   // ri pin, low active
);
    import ucr_pkg::*;

    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] mctl;
    logic [7:0] scratch;
    logic [7:0] xchr [4];
    logic wr_q;
    logic rd_q;
    logic wr_stb;
    logic rd_stb;
    logic enh_on;
    logic div_zero;
    ucr_bank_e bank;
    logic [7:0] next_rdata;
    logic [3:0] modem_lvl;

    // host strobes are treated as synchronous; act on the leading edge once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= !chan_select_n && !wr_n;
            rd_q <= !chan_select_n && !rd_n;
        end
    end
    assign wr_stb = !chan_select_n && !wr_n && !wr_q; // see RULE8
    assign rd_stb = !chan_select_n && !rd_n && !rd_q; // see RULE8

    function automatic ucr_bank_e pick_bank(input logic [7:0] lc);
        if (lc == LCTL_ENH_KEY)
            pick_bank = UCR_BANK_ENH;
        else if (lc[LCTL_DIV_BIT])
            pick_bank = UCR_BANK_DIV;
        else
            pick_bank = UCR_BANK_STD;
    endfunction

    assign bank = pick_bank(line_ctl); // see RULE18
    assign enh_on = enh_func[EFR_ENH_BIT]; // see RULE19
    assign div_zero = (div_low == DIV_ZERO) && (div_high == DIV_ZERO);
    assign baud_divisor = {div_high, div_low};
    assign flow_chars = {xchr[0], xchr[1], xchr[2], xchr[3]};
    assign loopback = mctl[MCTL_LOOP_BIT]; // see RULE1
    assign auto_flow_allow = !loopback; // see RULE6

    // register writes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            line_ctl <= RST_LCTL;
            div_low <= RST_DIV_LOW;
            div_high <= RST_ZERO;
            frac_divisor <= RST_ZERO;
            int_enable <= RST_ZERO;
            fifo_ctl <= RST_ZERO;
            mctl <= RST_ZERO;
            scratch <= RST_ZERO;
            enh_func <= RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                xchr[i] <= RST_ZERO;
            end
        end else if (wr_stb) begin
            case (addr)
                ADR_DATA: begin
                    if (bank == UCR_BANK_DIV)
                        div_low <= wdata; // see RULE10
                end
                ADR_IEN: begin
                    if (bank == UCR_BANK_DIV)
                        div_high <= wdata; // see RULE10
                    else if (bank == UCR_BANK_STD)
                        int_enable <= enh_on ? wdata : (wdata & ~IEN_EXT_MASK); // see RULE20
                end
                ADR_ISF: begin
                    if (bank == UCR_BANK_ENH)
                        enh_func <= wdata; // see RULE18
                    else if (bank == UCR_BANK_DIV && enh_on)
                        frac_divisor <= wdata & FRAC_MASK; // see RULE11
                    else
                        fifo_ctl <= enh_on ? wdata : (wdata & ~FCR_EXT_MASK); // see RULE15
                end
                ADR_LCTL: line_ctl <= wdata; // see RULE16
                default: begin
                    // only addresses 4..7 reach here, so the low two bits pick the character
                    if (bank == UCR_BANK_ENH)
                        xchr[addr[1:0]] <= wdata; // see RULE18
                    else if (addr == ADR_MCTL)
                        mctl <= enh_on ? wdata : (wdata & ~MCTL_EXT_MASK); // see RULE20
                    else if (addr == ADR_SCR)
                        scratch <= wdata; // see RULE17
                end
            endcase
        end
    end

    // fifo reset outputs self-clear: they act as one-cycle pulses, while fifo_ctl keeps the written reset bits
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fifo_rx_reset <= 1'b0;
            fifo_tx_reset <= 1'b0;
            tx_holding <= RST_ZERO;
            tx_holding_push <= 1'b0;
        end else begin
            fifo_rx_reset <= 1'b0;
            fifo_tx_reset <= 1'b0;
            tx_holding_push <= 1'b0;
            if (wr_stb && addr == ADR_ISF && bank != UCR_BANK_ENH
                && !(bank == UCR_BANK_DIV && enh_on)) begin
                fifo_rx_reset <= wdata[FCR_RXRST_BIT]; // see RULE15
                fifo_tx_reset <= wdata[FCR_TXRST_BIT]; // see RULE15
            end
            if (wr_stb && addr == ADR_DATA && bank == UCR_BANK_STD) begin
                tx_holding <= wdata; // see RULE9
                tx_holding_push <= 1'b1;
            end
        end
    end

    // modem inputs ignored in loopback, reported as inactive
    assign modem_lvl = loopback ? 4'h0 : {!cd_n_pin, !ri_n_pin, !dsr_n_pin, !cts_n_pin}; // see RULE4

    // read mux
    always_comb begin
        next_rdata = RST_ZERO;
        case (addr)
            ADR_DATA: begin
                if (bank == UCR_BANK_STD)
                    next_rdata = rx_holding; // see RULE9
                else if (bank == UCR_BANK_DIV)
                    next_rdata = div_zero ? REV_CODE : div_low; // see RULE12
                else
                    next_rdata = div_low;
            end
            ADR_IEN: begin
                if (bank == UCR_BANK_STD)
                    next_rdata = enh_on ? int_enable : (int_enable & ~IEN_EXT_MASK); // see RULE13
                else if (bank == UCR_BANK_DIV)
                    next_rdata = div_zero ? ID_CODE : div_high; // see RULE12
                else
                    next_rdata = div_high;
            end
            ADR_ISF: begin
                if (bank == UCR_BANK_ENH)
                    next_rdata = enh_func; // see RULE18
                else if (bank == UCR_BANK_DIV && enh_on)
                    next_rdata = frac_divisor; // see RULE11
                else begin
                    next_rdata = {2'b00, int_source} & ~(enh_on ? RST_ZERO : ISR_EXT_MASK); // see RULE14
                    next_rdata = next_rdata | (fifo_ctl[FCR_EN_BIT] ? ISR_FIFO_MASK : RST_ZERO);
                end
            end
            ADR_LCTL: next_rdata = line_ctl; // see RULE16
            ADR_MCTL: begin
                if (bank == UCR_BANK_ENH)
                    next_rdata = xchr[0];
                else
                    next_rdata = enh_on ? mctl : (mctl & ~MCTL_EXT_MASK); // see RULE17
            end
            ADR_LSTAT: next_rdata = (bank == UCR_BANK_ENH) ? xchr[1] : line_status_in;
            ADR_MSTAT: begin
                if (bank == UCR_BANK_ENH)
                    next_rdata = xchr[2];
                else
                    next_rdata = {modem_lvl, modem_delta}; // see RULE17
            end
            ADR_SCR: next_rdata = (bank == UCR_BANK_ENH) ? xchr[3] : scratch;
            default: next_rdata = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= RST_ZERO;
            rx_holding_pop <= 1'b0;
            isr_read <= 1'b0;
            line_status_read <= 1'b0;
            modem_status_read <= 1'b0;
        end else begin
            if (rd_stb)
                rdata <= next_rdata;
            rx_holding_pop <= rd_stb && addr == ADR_DATA && bank == UCR_BANK_STD;
            isr_read <= rd_stb && addr == ADR_ISF && bank != UCR_BANK_ENH
                && !(bank == UCR_BANK_DIV && enh_on);
            line_status_read <= rd_stb && addr == ADR_LSTAT && bank != UCR_BANK_ENH;
            modem_status_read <= rd_stb && addr == ADR_MSTAT && bank != UCR_BANK_ENH;
        end
    end
    assign rdata_oe = !chan_select_n && !rd_n && rd_q;

    // loopback path and held pins; internal uart activity is untouched
    assign rsr_in = loopback ? tsr_out : rx_pin; // see RULE2, see RULE5
    assign tx_pin = loopback ? 1'b1 : tsr_out; // see RULE3
    assign rts_n_pin = loopback ? 1'b1 : !mctl[MCTL_RTS_BIT]; // see RULE3
    assign dtr_n_pin = loopback ? 1'b1 : !mctl[MCTL_DTR_BIT]; // see RULE3

    AST_LOOP_PATH: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE2
        mctl[MCTL_LOOP_BIT] |-> (rsr_in == tsr_out))
        else $error("loopback path broken");
    AST_PIN_HELD: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE3
        loopback |-> (tx_pin && rts_n_pin && dtr_n_pin))
        else $error("pins not held in loopback");
    AST_MODEM_IGN: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE4
        loopback |-> (modem_lvl == 4'h0))
        else $error("modem inputs not ignored");
    AST_NO_AUTOFLOW: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE6
        loopback |-> !auto_flow_allow)
        else $error("auto flow allowed in loopback");
    AST_LCTL_WR: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE16
        (wr_stb && addr == ADR_LCTL) |=> (line_ctl == $past(wdata)))
        else $error("line control write lost");
    AST_IEN_GATE: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE20
        !enh_on && $past(wr_stb && addr == ADR_IEN && bank == UCR_BANK_STD && !enh_on)
        |-> ((int_enable & IEN_EXT_MASK) == RST_ZERO))
        else $error("gated enable bits written");
    AST_REV_READ: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE12
        (rd_stb && addr == ADR_DATA && bank == UCR_BANK_DIV && div_zero)
        |=> (rdata == REV_CODE))
        else $error("revision code not returned");
    AST_THR_PUSH: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE9
        (wr_stb && addr == ADR_DATA && bank == UCR_BANK_STD)
        |=> (tx_holding_push && tx_holding == $past(wdata)))
        else $error("transmit holding not loaded");
    AST_FRAC_GATE: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE11
        (wr_stb && addr == ADR_ISF && !enh_on) |=> $stable(frac_divisor))
        else $error("fractional divisor written while gated");

    // host accesses in steps: a strobe taken, then still held low on the next edge
    sequence seq_rd_held;
        rd_stb ##1 (!chan_select_n && !rd_n);
    endsequence
    sequence seq_wr_held;
        wr_stb ##1 (!chan_select_n && !wr_n);
    endsequence
    // a side-effect pulse must not stretch, or the fifo would be popped twice
    sequence seq_pop_once;
        rx_holding_pop ##1 !rx_holding_pop;
    endsequence

    AST_RD_DRIVE: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE8
        seq_rd_held |-> (rdata_oe && !rd_stb))
        else $error("held read not driven or taken twice");
    AST_WR_ONCE: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE8
        seq_wr_held |-> !wr_stb)
        else $error("held write taken twice");
    AST_RHR_POP: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE9
        (rd_stb && addr == ADR_DATA && bank == UCR_BANK_STD) |=> seq_pop_once)
        else $error("receive holding pop not a single pulse");
    AST_DIV_WR: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE10
        (wr_stb && addr == ADR_DATA && bank == UCR_BANK_DIV)
        |=> (div_low == $past(wdata)))
        else $error("divisor low write lost");
    AST_ISR_FIFO: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE14
        (rd_stb && addr == ADR_ISF && bank == UCR_BANK_STD)
        |=> ((rdata & ISR_FIFO_MASK)
            == ($past(fifo_ctl[FCR_EN_BIT]) ? ISR_FIFO_MASK : RST_ZERO)))
        else $error("fifo flags in interrupt status wrong");
    AST_FIFO_RST: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE15
        (wr_stb && addr == ADR_ISF && bank == UCR_BANK_STD)
        |=> (fifo_rx_reset == $past(wdata[FCR_RXRST_BIT])
            && fifo_tx_reset == $past(wdata[FCR_TXRST_BIT])))
        else $error("fifo reset pulses wrong");
    AST_LSR_HIDDEN: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE18
        (rd_stb && addr == ADR_LSTAT && bank == UCR_BANK_ENH)
        |=> (!line_status_read && rdata == $past(xchr[1])))
        else $error("line status reached in enhanced bank");
    AST_MSR_READ: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE17
        (rd_stb && addr == ADR_MSTAT && bank != UCR_BANK_ENH)
        |=> (modem_status_read && rdata == {$past(modem_lvl), $past(modem_delta)}))
        else $error("modem status read wrong");
    AST_SCR_WR: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE17
        (wr_stb && addr == ADR_SCR && bank != UCR_BANK_ENH)
        |=> (scratch == $past(wdata)))
        else $error("scratch write lost");
    AST_LOOP_SET: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE1
        (wr_stb && addr == ADR_MCTL && bank != UCR_BANK_ENH)
        |=> (loopback == $past(wdata[MCTL_LOOP_BIT])))
        else $error("loopback does not follow modem control");
endmodule // ucr_channel

/* design/ucr_pkg.sv */
package ucr_pkg;
    localparam int DW = 8;
    localparam int AW = 3;
    // register addresses
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IEN = 3'h1;
    localparam logic [2:0] ADR_ISF = 3'h2;
    localparam logic [2:0] ADR_LCTL = 3'h3;
    localparam logic [2:0] ADR_MCTL = 3'h4;
    localparam logic [2:0] ADR_LSTAT = 3'h5;
    localparam logic [2:0] ADR_MSTAT = 3'h6;
    localparam logic [2:0] ADR_SCR = 3'h7;
    // special line control and divisor values and field positions
    localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    localparam int LCTL_DIV_BIT = 7;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int MCTL_RTS_BIT = 1;
    localparam int MCTL_DTR_BIT = 0;
    localparam int EFR_ENH_BIT = 4;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXRST_BIT = 1;
    localparam int FCR_TXRST_BIT = 2;
    // masks of fields gated by the enhanced-enable bit; ISR_FIFO_MASK follows the fifo enable bit instead
    localparam logic [7:0] IEN_EXT_MASK = 8'hf0;
    localparam logic [7:0] ISR_EXT_MASK = 8'h30;
    localparam logic [7:0] FCR_EXT_MASK = 8'h30;
    localparam logic [7:0] MCTL_EXT_MASK = 8'he0;
    localparam logic [7:0] FRAC_MASK = 8'h3f;
    localparam logic [7:0] ISR_FIFO_MASK = 8'hc0;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_LCTL = 8'h00;
    localparam logic [7:0] RST_DIV_LOW = 8'h01;
    // identity codes: arbitrary neutral values
    localparam logic [7:0] REV_CODE_DEF = 8'h01;
    localparam logic [7:0] ID_CODE_DEF = 8'h5a;
    // register windows
    typedef enum logic [1:0] {
        UCR_BANK_STD = 2'b00,
        UCR_BANK_DIV = 2'b01,
        UCR_BANK_ENH = 2'b10
    } ucr_bank_e;
endpackage

/* verif/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    import ucr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    int fails = 0;
    int comparisons = 0;
    int cnt [8] = '{default: 0};
    int exp_cnt [8] = '{1, 1, 2, 1, 2, 1, 1, 0};
    logic [31:0] seed = 32'd82655;
    logic [31:0] fc;
    logic [1:0] sel_n, oe, pop, push, interrupt_status, line_status, modem_status, rxr, txr, afa, lpb, rsr, txp, rts, dtr;
    logic [2:0] addr;
    logic wr_n, rd_n, rx_pin, qo;
    logic tsr_out = 1'b0;
    logic [7:0] wdata, q, v, w, pl;
    logic [7:0] rx_holding = 8'h00;
    logic [7:0] lsin = 8'h00;
    logic [5:0] int_source = 6'h00;
    logic [3:0] mdelta = 4'h0;
    logic [3:0] mpins = 4'hf;
    logic [7:0] rdata [2], txh [2], fctl [2], ien [2], lctl [2], frac [2], enhanced_function [2];
    logic [15:0] bdiv [2];
    logic [31:0] flow [2];

    always #2 clk_sys = ~clk_sys;
    assign pl = {|{pop[1], push[1], interrupt_status[1], line_status[1], modem_status[1], rxr[1], txr[1]},
                 txr[0], rxr[0], modem_status[0], line_status[0], interrupt_status[0], push[0], pop[0]};
    for (genvar c = 0; c < 2; c++) begin : g_ch
        ucr_channel ucr_channel_inst (
            .clk_sys(clk_sys), .reset_n(reset_n), .chan_select_n(sel_n[c]), .addr(addr),
            .wr_n(wr_n), .rd_n(rd_n), .wdata(wdata), .rdata(rdata[c]), .rdata_oe(oe[c]),
            .rx_holding(rx_holding), .rx_holding_pop(pop[c]), .tx_holding(txh[c]),
            .tx_holding_push(push[c]), .int_source(int_source), .int_source_rd_ack(1'b0),
            .isr_read(interrupt_status[c]), .line_status_in(lsin), .line_status_read(line_status[c]),
            .modem_delta(mdelta), .modem_status_read(modem_status[c]), .fifo_rx_reset(rxr[c]),
            .fifo_tx_reset(txr[c]), .fifo_ctl(fctl[c]), .int_enable(ien[c]),
            .line_ctl(lctl[c]), .baud_divisor(bdiv[c]), .frac_divisor(frac[c]),
            .enh_func(enhanced_function[c]), .flow_chars(flow[c]), .auto_flow_allow(afa[c]),
            .loopback(lpb[c]), .tsr_out(tsr_out), .rsr_in(rsr[c]), .rx_pin(rx_pin),
            .tx_pin(txp[c]), .rts_n_pin(rts[c]), .dtr_n_pin(dtr[c]), .cts_n_pin(mpins[0]),
            .dsr_n_pin(mpins[1]), .ri_n_pin(mpins[2]), .cd_n_pin(mpins[3])
        );
    end
    ucr_host_model ucr_host_model_inst (
        .clk_sys(clk_sys), .rdata_a(rdata[0]), .rdata_b(rdata[1]), .oe(oe), .sel_n(sel_n),
        .addr(addr), .wr_n(wr_n), .rd_n(rd_n), .wdata(wdata), .rx_pin(rx_pin)
    );
    // a pulse stretched past one cycle shows up as an extra count
    always @(posedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (reset_n && pl[i]) begin
                cnt[i]++;
            end
        end
    end
    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] gate(input logic [7:0] x, m, input logic en);
        return en ? x : (x & ~m);
    endfunction
    task automatic wr(input bit ch, input logic [2:0] a, input logic [7:0] d);
        ucr_host_model_inst.xfer(ch, 1'b1, a, d, q, qo);
    endtask
    task automatic rdc(input bit ch, input logic [2:0] a, input logic [7:0] e);
        ucr_host_model_inst.xfer(ch, 1'b0, a, 8'h00, q, qo);
        `CHK(q, e)
        `CHK(qo, 1'b1)
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        rdc(0, ADR_LCTL, RST_LCTL);
        rdc(0, ADR_IEN, RST_ZERO);
        v = rnd();
        w = rnd();
        wr(0, ADR_SCR, v);
        wr(1, ADR_SCR, w);
        rdc(0, ADR_SCR, v);
        rdc(1, ADR_SCR, w);
        wr(0, ADR_DATA, v);
        `CHK(txh[0], v)
        rx_holding = w;
        rdc(0, ADR_DATA, w);
        wr(0, ADR_IEN, 8'hff);
        rdc(0, ADR_IEN, gate(8'hff, IEN_EXT_MASK, 1'b0));
        `CHK(ien[0], 8'h0f)
        wr(0, ADR_LCTL, LCTL_ENH_KEY);
        rdc(0, ADR_LCTL, LCTL_ENH_KEY);
        `CHK(lctl[0], LCTL_ENH_KEY)
        wr(0, ADR_ISF, 8'h10);
        `CHK(enhanced_function[0], 8'h10)
        rdc(0, ADR_ISF, 8'h10);
        for (int a = 4; a < 8; a++) begin
            v = rnd();
            fc = {fc[23:0], v};
            wr(0, 3'(a), v);
            rdc(0, 3'(a), v);
        end
        `CHK(flow[0], fc)
        wr(0, ADR_LCTL, 8'h00);
        wr(0, ADR_IEN, 8'hff);
        rdc(0, ADR_IEN, 8'hff);
        int_source = 6'(rnd());
        wr(0, ADR_ISF, 8'h37);
        `CHK(fctl[0] & 8'hf9, 8'h31)
        rdc(0, ADR_ISF, {2'b11, int_source});
        wr(0, ADR_LCTL, 8'h80);
        rdc(0, ADR_DATA, RST_DIV_LOW);
        v = rnd() | 8'h01;
        w = rnd();
        wr(0, ADR_DATA, v);
        wr(0, ADR_IEN, w);
        rdc(0, ADR_DATA, v);
        rdc(0, ADR_IEN, w);
        `CHK(bdiv[0], {w, v})
        wr(0, ADR_ISF, 8'hff);
        rdc(0, ADR_ISF, FRAC_MASK);
        wr(0, ADR_DATA, DIV_ZERO);
        wr(0, ADR_IEN, DIV_ZERO);
        rdc(0, ADR_DATA, REV_CODE_DEF);
        rdc(0, ADR_IEN, ID_CODE_DEF);
        wr(0, ADR_LCTL, 8'h00);
        lsin = rnd();
        wr(0, ADR_LSTAT, ~lsin);
        rdc(0, ADR_LSTAT, lsin);
        v = rnd();
        mpins = v[3:0];
        mdelta = v[7:4];
        rdc(0, ADR_MSTAT, {~mpins, mdelta});
        wr(0, ADR_MCTL, 8'h03);
        `CHK({lpb[0], afa[0], txp[0], rts[0], dtr[0], rsr[0]}, 6'b010001)
        wr(0, ADR_MCTL, 8'h13);
        for (int t = 0; t < 2; t++) begin
            tsr_out = t[0];
            #1;
            `CHK({lpb[0], afa[0], txp[0], rts[0], dtr[0], rsr[0]}, {5'b10111, t[0]})
        end
        rdc(0, ADR_MSTAT, {4'h0, mdelta});
        wr(0, ADR_SCR, w);
        rdc(0, ADR_SCR, w);
        rdc(0, ADR_MCTL, 8'h13);
        wr(0, ADR_MCTL, 8'he3);
        rdc(0, ADR_MCTL, 8'he3);
        `CHK({lpb[0], rsr[0]}, 2'b01)
        wr(0, ADR_LCTL, LCTL_ENH_KEY);
        wr(0, ADR_ISF, 8'h00);
        wr(0, ADR_LCTL, 8'h80);
        wr(0, ADR_ISF, 8'h01);
        `CHK(frac[0], FRAC_MASK)
        wr(0, ADR_LCTL, 8'h00);
        wr(0, ADR_MCTL, 8'he3);
        rdc(0, ADR_MCTL, gate(8'he3, MCTL_EXT_MASK, 1'b0));
        rdc(0, ADR_ISF, gate({2'b11, int_source}, ISR_EXT_MASK, 1'b0));
        `CHK({lctl[1], ien[1], enhanced_function[1]}, {RST_LCTL, RST_ZERO, RST_ZERO})
        for (int i = 0; i < 8; i++) begin
            `CHK(cnt[i], exp_cnt[i])
        end
        tally_and_finish();
    end
endmodule // tb

/* verif/ucr_host_model.sv */
`timescale 1ns/10ps
module ucr_host_model (
    input wire logic clk_sys,       // system clock
    input wire logic [7:0] rdata_a, // channel a read data
    input wire logic [7:0] rdata_b, // channel b read data
    input wire logic [1:0] oe,      // data drive enables
    output logic [1:0] sel_n,       // channel selects, low
    output logic [2:0] addr,        // register address
    output logic wr_n,              // write strobe, low
    output logic rd_n,              // read strobe, low
    output logic [7:0] wdata,       // write data
    output logic rx_pin             // serial receive pin
);
    initial begin
        rx_pin = 1'b1;
        sel_n = 2'b11;
        addr = 3'h0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        wdata = 8'h00;
    end
    // held over two edges so registered read data has surely landed
    task automatic xfer(input bit ch, input bit wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic q_oe);
        @(negedge clk_sys);
        sel_n[ch] = 1'b0;
        addr = a;
        wdata = d;
        wr_n = !wr;
        rd_n = wr;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        q = ch ? rdata_b : rdata_a;
        q_oe = oe[ch];
        sel_n = 2'b11;
        wr_n = 1'b1;
        rd_n = 1'b1;
        // a released bus never keeps its last value
        addr = ~addr;
        wdata = ~wdata;
    endtask
endmodule // ucr_host_model
